/* hdl/core_register_file_banked.sv */
// banked core register file with two indirect data memory ports
// Behaviour
// - the core set decodes at offsets 00h-0bh and 80h-8bh of every bank, whatever the bank.
// - the program counter high latch holds 7 bits, bit 7 reads zero, and any reset clears it.
// - pointer 1 high forms the upper byte of the second indirect address and any reset clears it.
// - unimplemented bits of the core set read as zero and writes to them do nothing.
// - indirect port 0 reads or writes data memory at pointer 0 high and low.
// - indirect port 1 reads or writes data memory at pointer 1 high and low.
// - program counter low shows the low program counter byte and any reset clears it.
module core_register_file_banked (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic soft_rst_in,
    input wire core_regs_pkg::access_type req_in,
    output logic ready_out,
    output logic rvalid_out,
    output logic [7:0] rdata_out,
    output core_regs_pkg::mem_access_type mem_out,
    input wire logic [7:0] mem_rdata_in,
    input wire logic pc_load_in,
    input wire logic [7:0] pc_low_in,
    output logic [7:0] pc_low_out,
    output logic pc_written_out,
    output logic [6:0] pc_latch_out,
    output logic [4:0] bank_out,
    output logic [7:0] work_out,
    input wire logic flags_load_in,
    input wire logic [7:0] flags_in,
    output logic [7:0] flags_out,
    input wire logic [2:0] int_flags_set_in,
    output logic [7:0] int_ctrl_out
);
    typedef enum logic {st_idle, st_ind_read} ind_state_type;

    ind_state_type state_reg, state_next;
    logic ready_reg, ready_next;
    logic rvalid_reg, rvalid_next;
    logic [7:0] rdata_reg, rdata_next;
    core_regs_pkg::mem_access_type mem_reg, mem_next;
    logic [7:0] pc_low_reg, pc_low_next;
    logic pc_written_reg, pc_written_next;
    logic [6:0] pc_latch_reg, pc_latch_next;
    logic [4:0] bank_reg, bank_next;
    logic [7:0] work_reg, work_next;
    logic [7:0] flags_reg, flags_next;
    logic [7:0] int_ctrl_reg, int_ctrl_next;
    logic [7:0] ptr0_low_reg, ptr0_low_next;
    logic [7:0] ptr0_high_reg, ptr0_high_next;
    logic [7:0] ptr1_low_reg, ptr1_low_next;
    logic [7:0] ptr1_high_reg, ptr1_high_next;
    logic [6:0] ofs;
    logic hit;
    logic take;

    // folds bit 7 so upper half aliases the lower, bank bits ignored
    function automatic logic [6:0] fold_offset(input logic [11:0] addr);
        fold_offset = addr[6:0];
    endfunction

    function automatic logic core_hit(input logic [6:0] o);
        core_hit = o < core_regs_pkg::ofs_count;
    endfunction

    assign ofs = fold_offset(req_in.addr);
    assign hit = core_hit(ofs);
    assign take = ready_reg && (req_in.rd || req_in.wr) && hit;

    always_comb begin
        state_next = st_idle;
        ready_next = 1'b1;
        rvalid_next = 1'b0;
        rdata_next = rdata_reg;
        mem_next = '0;
        pc_low_next = pc_low_reg;
        pc_written_next = 1'b0;
        pc_latch_next = pc_latch_reg;
        bank_next = bank_reg;
        work_next = work_reg;
        flags_next = flags_reg;
        int_ctrl_next = int_ctrl_reg;
        ptr0_low_next = ptr0_low_reg;
        ptr0_high_next = ptr0_high_reg;
        ptr1_low_next = ptr1_low_reg;
        ptr1_high_next = ptr1_high_reg;
        if (pc_load_in) begin
            pc_low_next = pc_low_in;
        end
        if (flags_load_in) begin
            flags_next = flags_in & {3'h0, 5'h1f};
        end
        if (state_reg == st_ind_read) begin
            rvalid_next = 1'b1;
            rdata_next = mem_rdata_in;
        end else if (take && req_in.rd) begin
            rvalid_next = 1'b1;
            case (ofs)
                core_regs_pkg::ofs_ind0: begin
                    // answer waits one cycle for data memory
                    mem_next.rd = 1'b1;
                    mem_next.addr = {ptr0_high_reg, ptr0_low_reg};
                    rvalid_next = 1'b0;
                    ready_next = 1'b0;
                    state_next = st_ind_read;
                end
                core_regs_pkg::ofs_ind1: begin
                    mem_next.rd = 1'b1;
                    mem_next.addr = {ptr1_high_reg, ptr1_low_reg};
                    rvalid_next = 1'b0;
                    ready_next = 1'b0;
                    state_next = st_ind_read;
                end
                core_regs_pkg::ofs_pc_low: rdata_next = pc_low_reg;
                core_regs_pkg::ofs_flags: rdata_next = flags_reg;
                core_regs_pkg::ofs_ptr0_low: rdata_next = ptr0_low_reg;
                core_regs_pkg::ofs_ptr0_high: rdata_next = ptr0_high_reg;
                core_regs_pkg::ofs_ptr1_low: rdata_next = ptr1_low_reg;
                core_regs_pkg::ofs_ptr1_high: rdata_next = ptr1_high_reg;
                core_regs_pkg::ofs_bank: rdata_next = {3'h0, bank_reg};
                core_regs_pkg::ofs_work: rdata_next = work_reg;
                core_regs_pkg::ofs_pc_latch: rdata_next = {1'b0, pc_latch_reg};
                core_regs_pkg::ofs_int_ctrl: rdata_next = int_ctrl_reg;
                default: rdata_next = 8'h00;
            endcase
        end else if (take && req_in.wr) begin
            case (ofs)
                core_regs_pkg::ofs_ind0: begin
                    mem_next.wr = 1'b1;
                    mem_next.addr = {ptr0_high_reg, ptr0_low_reg};
                    mem_next.wdata = req_in.wdata;
                end
                core_regs_pkg::ofs_ind1: begin
                    mem_next.wr = 1'b1;
                    mem_next.addr = {ptr1_high_reg, ptr1_low_reg};
                    mem_next.wdata = req_in.wdata;
                end
                core_regs_pkg::ofs_pc_low: begin
                    pc_low_next = req_in.wdata;
                    pc_written_next = 1'b1;
                end
                // timeout and power-down bits stay hardware owned
                core_regs_pkg::ofs_flags: flags_next = (flags_next & ~core_regs_pkg::flags_sw_mask)
                    | (req_in.wdata & core_regs_pkg::flags_sw_mask);
                core_regs_pkg::ofs_ptr0_low: ptr0_low_next = req_in.wdata;
                core_regs_pkg::ofs_ptr0_high: ptr0_high_next = req_in.wdata;
                core_regs_pkg::ofs_ptr1_low: ptr1_low_next = req_in.wdata;
                core_regs_pkg::ofs_ptr1_high: ptr1_high_next = req_in.wdata;
                core_regs_pkg::ofs_bank: bank_next = req_in.wdata[4:0];
                core_regs_pkg::ofs_work: work_next = req_in.wdata;
                core_regs_pkg::ofs_pc_latch: pc_latch_next = req_in.wdata[6:0];
                core_regs_pkg::ofs_int_ctrl: int_ctrl_next = req_in.wdata;
                default: bank_next = bank_reg;
            endcase
        end
        // hardware set wins over a software clear in the same cycle
        int_ctrl_next = int_ctrl_next | {5'h00, int_flags_set_in};
        if (soft_rst_in) begin
            // low pointers and working register survive this reset
            state_next = st_idle;
            ready_next = 1'b1;
            rvalid_next = 1'b0;
            mem_next = '0;
            pc_low_next = core_regs_pkg::rst_zero;
            pc_written_next = 1'b0;
            pc_latch_next = core_regs_pkg::rst_zero[6:0];
            bank_next = core_regs_pkg::rst_zero[4:0];
            int_ctrl_next = core_regs_pkg::rst_zero;
            ptr0_high_next = core_regs_pkg::rst_zero;
            ptr1_high_next = core_regs_pkg::rst_zero;
            work_next = work_reg;
            ptr0_low_next = ptr0_low_reg;
            ptr1_low_next = ptr1_low_reg;
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_reg <= st_idle;
            ready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= core_regs_pkg::rst_zero;
            mem_reg <= '0;
            pc_low_reg <= core_regs_pkg::rst_zero;
            pc_written_reg <= 1'b0;
            pc_latch_reg <= core_regs_pkg::rst_zero[6:0];
            bank_reg <= core_regs_pkg::rst_zero[4:0];
            work_reg <= core_regs_pkg::rst_zero;
            flags_reg <= core_regs_pkg::rst_flags;
            int_ctrl_reg <= core_regs_pkg::rst_zero;
            ptr0_low_reg <= core_regs_pkg::rst_zero;
            ptr0_high_reg <= core_regs_pkg::rst_zero;
            ptr1_low_reg <= core_regs_pkg::rst_zero;
            ptr1_high_reg <= core_regs_pkg::rst_zero;
        end else begin
            state_reg <= state_next;
            ready_reg <= ready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            mem_reg <= mem_next;
            pc_low_reg <= pc_low_next;
            pc_written_reg <= pc_written_next;
            pc_latch_reg <= pc_latch_next;
            bank_reg <= bank_next;
            work_reg <= work_next;
            flags_reg <= flags_next;
            int_ctrl_reg <= int_ctrl_next;
            ptr0_low_reg <= ptr0_low_next;
            ptr0_high_reg <= ptr0_high_next;
            ptr1_low_reg <= ptr1_low_next;
            ptr1_high_reg <= ptr1_high_next;
        end
    end

    assign ready_out = ready_reg;
    assign rvalid_out = rvalid_reg;
    assign rdata_out = rdata_reg;
    assign mem_out = mem_reg;
    assign pc_low_out = pc_low_reg;
    assign pc_written_out = pc_written_reg;
    assign pc_latch_out = pc_latch_reg;
    assign bank_out = bank_reg;
    assign work_out = work_reg;
    assign flags_out = flags_reg;
    assign int_ctrl_out = int_ctrl_reg;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    chk_mirror_read_answers: assert property (
        (take && req_in.rd && ofs > core_regs_pkg::ofs_ind1 && !soft_rst_in) |=> rvalid_out)
        else $error("core offset read in any bank got no answer");
    chk_latch_top_zero: assert property (
        (take && req_in.rd && ofs == core_regs_pkg::ofs_pc_latch && !soft_rst_in)
        |=> rdata_out == {1'b0, $past(pc_latch_out)})
        else $error("latch read wrong or top bit set");
    chk_ptr1_high_clear: assert property (
        soft_rst_in |=> ptr1_high_reg == 8'h00)
        else $error("pointer 1 high survived reset");
    chk_bank_unused_zero: assert property (
        (take && req_in.rd && ofs == core_regs_pkg::ofs_bank && !soft_rst_in)
        |=> rdata_out == {3'h0, $past(bank_out)})
        else $error("unimplemented bank bits read nonzero");
    chk_ind0_addr: assert property (
        (take && req_in.rd && ofs == core_regs_pkg::ofs_ind0 && !soft_rst_in)
        |=> mem_out.rd && mem_out.addr == {$past(ptr0_high_reg), $past(ptr0_low_reg)}
        ##1 rvalid_out && rdata_out == $past(mem_rdata_in))
        else $error("indirect port 0 read misdirected");
    chk_ind1_write: assert property (
        (take && req_in.wr && ofs == core_regs_pkg::ofs_ind1 && !soft_rst_in)
        |=> mem_out.wr && mem_out.addr == {$past(ptr1_high_reg), $past(ptr1_low_reg)})
        else $error("indirect port 1 write misdirected");
    chk_pc_low_clear: assert property (
        soft_rst_in |=> pc_low_out == 8'h00 && pc_latch_out == 7'h00)
        else $error("program counter bytes survived reset");
    chk_work_kept: assert property (
        soft_rst_in |=> work_out == $past(work_out) && ptr0_low_reg == $past(ptr0_low_reg))
        else $error("working register lost on soft reset");
    cov_ind_read: cover property (take && req_in.rd && ofs == core_regs_pkg::ofs_ind1 ##2 rvalid_out);
    cov_upper_half: cover property (take && req_in.wr && req_in.addr[7]);
    cov_set_clear: cover property (take && req_in.wr && ofs == core_regs_pkg::ofs_int_ctrl
        && int_flags_set_in != 3'h0);
endmodule

/* inc/core_regs_pkg.sv */
// constants and carrier types of the banked core register file
package core_regs_pkg;
    localparam logic [6:0] ofs_ind0 = 7'h00;
    localparam logic [6:0] ofs_ind1 = 7'h01;
    localparam logic [6:0] ofs_pc_low = 7'h02;
    localparam logic [6:0] ofs_flags = 7'h03;
    localparam logic [6:0] ofs_ptr0_low = 7'h04;
    localparam logic [6:0] ofs_ptr0_high = 7'h05;
    localparam logic [6:0] ofs_ptr1_low = 7'h06;
    localparam logic [6:0] ofs_ptr1_high = 7'h07;
    localparam logic [6:0] ofs_bank = 7'h08;
    localparam logic [6:0] ofs_work = 7'h09;
    localparam logic [6:0] ofs_pc_latch = 7'h0a;
    localparam logic [6:0] ofs_int_ctrl = 7'h0b;
    localparam logic [6:0] ofs_count = 7'h0c;
    // offset within a bank, upper half folded onto the lower
    localparam int ofs_width = 7;
    localparam int bank_width = 5;
    localparam int latch_width = 7;
    localparam logic [7:0] rst_zero = 8'h00;
    localparam logic [7:0] rst_flags = 8'h18;
    localparam int flag_timeout_bit = 4;
    localparam int flag_powerdown_bit = 3;
    localparam logic [7:0] flags_sw_mask = 8'h07;
    localparam logic [7:0] int_ctrl_sw_mask = 8'hfe;
    localparam logic [7:0] int_ctrl_hw_mask = 8'h07;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
    } access_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } mem_access_type;
endpackage

/* tb/test_core_register_file_banked.sv */
// self-checking bench for the banked core register file
module test_core_register_file_banked;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_in;
    logic sys_rst_in;
    logic soft_rst_in;
    core_regs_pkg::access_type req;
    logic ready_out, rvalid_out, pc_written_out, pc_load_in, flags_load_in;
    logic [7:0] rdata_out, mem_rdata_in, pc_low_in, pc_low_out, work_out, flags_out;
    logic [7:0] flags_in, int_ctrl_out;
    logic [6:0] pc_latch_out;
    logic [4:0] bank_out;
    logic [2:0] int_flags_set_in;
    core_regs_pkg::mem_access_type mem_out, mem_seen;
    logic pcw_seen;
    logic [7:0] d;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    // expected contents of offsets 0..11 after power-on and after a soft reset
    logic [7:0] por_tab [12] = '{8'h00, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'h00, 8'h00,
                                 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] soft_tab [12] = '{8'h00, 8'h00, 8'h00, 8'h1f, 8'h34, 8'h00, 8'h78, 8'h00,
                                  8'h00, 8'h66, 8'h00, 8'h00};

    core_register_file_banked dut (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .soft_rst_in(soft_rst_in),
        .req_in(req), .ready_out(ready_out), .rvalid_out(rvalid_out),
        .rdata_out(rdata_out), .mem_out(mem_out), .mem_rdata_in(mem_rdata_in),
        .pc_load_in(pc_load_in), .pc_low_in(pc_low_in), .pc_low_out(pc_low_out),
        .pc_written_out(pc_written_out), .pc_latch_out(pc_latch_out),
        .bank_out(bank_out), .work_out(work_out), .flags_load_in(flags_load_in),
        .flags_in(flags_in), .flags_out(flags_out),
        .int_flags_set_in(int_flags_set_in), .int_ctrl_out(int_ctrl_out)
    );

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    task automatic close_out();
        if (n_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // hang guard, the full run needs about 130 cycles
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // each access starts one edge later, so a request is never lowered and raised at once
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge clock_in);
        #1 req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
        @(posedge clock_in);
        #1 req = '0;
        mem_seen = mem_out;
        pcw_seen = pc_written_out;
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] v);
        int k;
        @(posedge clock_in);
        #1 req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clock_in);
        #1 req = '0;
        v = 8'h00;
        for (k = 0; k < 4 && rvalid_out !== 1'b1; k++) begin
            if (mem_out.rd === 1'b1) mem_seen = mem_out;
            if (mem_out.rd === 1'b1) check("ready busy", {15'h0000, ready_out}, 16'h0000);
            @(posedge clock_in);
            #1;
        end
        if (rvalid_out === 1'b1) v = rdata_out;
        else check("read answer", 16'h0000, 16'h0001);
    endtask

    // reads offsets 2..11 through the upper half of bank 3
    task automatic check_all(input string what, input logic [7:0] tab [12]);
        logic [7:0] v;
        for (int i = 2; i < 12; i++) begin
            rd(12'h180 | 12'(i), v);
            check(what, {8'h00, v}, {8'h00, tab[i]});
        end
    endtask

    task automatic pulse_soft();
        @(posedge clock_in);
        #1 soft_rst_in = 1'b1;
        @(posedge clock_in);
        #1 soft_rst_in = 1'b0;
    endtask

    initial begin
        sys_rst_in = 1'b1;
        soft_rst_in = 1'b0;
        req = '0;
        mem_rdata_in = 8'h00;
        pc_load_in = 1'b0;
        pc_low_in = 8'h00;
        flags_load_in = 1'b0;
        flags_in = 8'h00;
        int_flags_set_in = 3'b000;
        repeat (3) @(posedge clock_in);
        #1 sys_rst_in = 1'b0;
        check_all("power-on value", por_tab);
        for (int b = 0; b < 32; b += 5) begin
            wr({5'(b), 7'(b[0] ? 8'h89 : 8'h09)}, 8'(b + 8'h40));
            rd({5'(31 - b), 7'h09}, d);
            check("mirrored work", {8'h00, d}, 16'(b + 8'h40));
        end
        wr(12'h00a, 8'hff);
        check("latch port", {9'h000, pc_latch_out}, 16'h007f);
        rd(12'hf8a, d);
        check("latch read", {8'h00, d}, 16'h007f);
        wr(12'h088, 8'hff);
        check("bank port", {11'h000, bank_out}, 16'h001f);
        wr(12'h003, 8'hff);
        check("flags port", {8'h00, flags_out}, 16'h001f);
        flags_in = 8'hff;
        flags_load_in = 1'b1;
        @(posedge clock_in);
        #1 flags_load_in = 1'b0;
        check("flags load", {8'h00, flags_out}, 16'h001f);
        int_flags_set_in = 3'b101;
        @(posedge clock_in);
        #1 int_flags_set_in = 3'b000;
        check("int ctrl set", {8'h00, int_ctrl_out}, 16'h0005);
        // hardware set held across a software write must survive it
        int_flags_set_in = 3'b010;
        wr(12'h08b, 8'hf8);
        int_flags_set_in = 3'b000;
        check("int ctrl set wins", {8'h00, int_ctrl_out}, 16'h00fa);
        wr(12'h285, 8'h12);
        wr(12'h304, 8'h34);
        mem_rdata_in = 8'ha5;
        rd(12'h080, d);
        check("port0 read data", {8'h00, d}, 16'h00a5);
        check("port0 address", mem_seen.addr, 16'h1234);
        check("port0 read strobe", {15'h0000, mem_seen.rd}, 16'h0001);
        check("ready after port0", {15'h0000, ready_out}, 16'h0001);
        rd(12'h004, d);
        check("ptr0 low after port0", {8'h00, d}, 16'h0034);
        wr(12'h000, 8'h77);
        check("port0 write strobe", {15'h0000, mem_seen.wr}, 16'h0001);
        check("port0 write address", mem_seen.addr, 16'h1234);
        check("port0 write data", {8'h00, mem_seen.wdata}, 16'h0077);
        wr(12'h787, 8'h56);
        wr(12'h006, 8'h78);
        wr(12'h081, 8'hc3);
        check("port1 strobe", {15'h0000, mem_seen.wr}, 16'h0001);
        check("port1 address", mem_seen.addr, 16'h5678);
        check("port1 data", {8'h00, mem_seen.wdata}, 16'h00c3);
        mem_rdata_in = 8'h3c;
        rd(12'hf81, d);
        check("port1 read data", {8'h00, d}, 16'h003c);
        check("port1 read address", mem_seen.addr, 16'h5678);
        check("port1 read strobe", {15'h0000, mem_seen.rd}, 16'h0001);
        pc_low_in = 8'h5a;
        pc_load_in = 1'b1;
        @(posedge clock_in);
        #1 pc_load_in = 1'b0;
        check("pc low load", {8'h00, pc_low_out}, 16'h005a);
        wr(12'h102, 8'h9b);
        check("pc low write", {8'h00, pc_low_out}, 16'h009b);
        check("pc written", {15'h0000, pcw_seen}, 16'h0001);
        wr(12'h009, 8'h66);
        pulse_soft();
        check_all("soft reset value", soft_tab);
        check("work port", {8'h00, work_out}, 16'h0066);
        @(posedge clock_in);
        #1 sys_rst_in = 1'b1;
        @(posedge clock_in);
        #1 sys_rst_in = 1'b0;
        check_all("second power-on value", por_tab);
        close_out();
    end
endmodule
